/* File: rtl/timer_pulse_pkg.sv */
// constants and types for the pulse-mode timer
package timer_pulse_pkg;

	// ==========================================================
	// mode select encodings
	typedef enum logic [2:0] {
		MODE_DUTY  = 3'b010,
		MODE_SHOT  = 3'b011,
		MODE_PWM   = 3'b100,
		MODE_OTHER = 3'b111
	} mode_t;

	// ==========================================================
	// output control encodings
	localparam logic [1:0] OC_HIZ    = 2'h0;
	localparam logic [1:0] OC_TOGGLE = 2'h1;
	localparam logic [1:0] OC_ZERO   = 2'h2;
	localparam logic [1:0] OC_ONE    = 2'h3;

	// ==========================================================
	// widths and reset values
	localparam int          CNT_W       = 16;
	localparam int          PRE_W       = 8;
	localparam logic [15:0] CNT_ALL_ONE = 16'hFFFF;
	localparam logic [15:0] CNT_RST     = 16'h0000;
	localparam logic [7:0]  PRE_RST     = 8'hFF;

	// ==========================================================
	// interrupt enable bit positions
	localparam int IE_TIMEOUT = 0;
	localparam int IE_GATE    = 1;
	localparam int IE_COMPARE = 2;

	// ==========================================================
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LOAD  = 2'b01,
		ST_COUNT = 2'b10,
		ST_DONE  = 2'b11
	} state_t;

endpackage

/* File: rtl/timer_pulse_modes.sv */
// pulse-mode timer: duty-cycle generator, single shot and pulse-width measurement
`timescale 1ns/1ns

// How it works
// - mode 010 runs the two-preload variable duty-cycle square wave.
// - enable needs soft_run, prescaler_enable and gate if gated; then running, load first preload.
// - counter decrements on each counter-clock falling edge after a load until it reaches zero.
// - duty mode reloads second then first preload after each time-out, forever.
// - compare match sets compare and event flags; zero sets timeout, clears compare.
// - toggle output flips at every time-out.
// - gated generator stops on gate negation, sets gate event, resumes on reassertion.
// - gate ignored when gate_enable clear; gate event never set then.
// - gate level flag follows the gate input always.
// - output level flag follows the driven timer output.
// - preload write colliding with its own reload may load old value; other is safe.
// - single shot stops after second time-out, clearing running and compare flags.
// - single shot toggle output low until first time-out, high, then low again.
// - second preload may be rewritten during the first countdown.
// - mode 100 measures pulse width over the first gate assertion only.
// - measurement needs gate_enable; gate starts it, loads all ones, no preloads.
// - measurement gate negation sets gate event, clears running, holds count forever.
// - measurement time-out sets timeout, reloads all ones; output per output control.
// - counter wraps as 16-bit; prescaler bits extend the count downward.
// - gate event flag clears only on a software write-one strobe.
// - interrupt request asserted while any enabled flag is set.
module timer_pulse_modes
	import timer_pulse_pkg::*;
(
	input  wire logic              mclk,                   // system clock
	input  wire logic              nrst,                   // sync reset, active low
	input  wire logic              counter_clock,          // selected counter clock level
	input  wire logic              gate_input_n,           // gate pin, active low
	input  wire logic [2:0]        mode_select,            // control: operating mode
	input  wire logic              soft_run,               // control: run
	input  wire logic              prescaler_enable,       // control: prescaler enable
	input  wire logic              gate_enable,            // control: gate controls timer
	input  wire logic [1:0]        output_control,         // control: output behaviour
	input  wire logic [2:0]        interrupt_enable_bits,  // control: flag to irq enables
	input  wire logic [CNT_W-1:0]  first_preload,          // first preload value
	input  wire logic [CNT_W-1:0]  second_preload,         // second preload value
	input  wire logic [CNT_W-1:0]  compare_value,          // compare register
	input  wire logic              clear_timeout,          // write-one clear strobe
	input  wire logic              clear_gate_event,       // write-one clear strobe
	input  wire logic              clear_compare_event,    // write-one clear strobe
	output logic [CNT_W-1:0]       count_register,         // current count
	output logic [PRE_W-1:0]       prescaler_output_bits,  // prescaler state
	output logic                   running_flag,           // timer enabled
	output logic                   compare_flag,           // count reached compare
	output logic                   compare_event_flag,     // sticky compare event
	output logic                   timeout_flag,           // sticky time-out
	output logic                   gate_event_flag,        // sticky gate event
	output logic                   gate_level_flag,        // gate pin level
	output logic                   output_level_flag,      // timer output level
	output logic                   timer_output,           // timer output pin value
	output logic                   timer_output_oe,        // timer output drive enable
	output logic                   interrupt_request_line  // interrupt request
);

	// ==========================================================
	// input sampling
	// pins are synchronous here, so one flop is enough to align them
	logic   cclk_q;
	logic   gate_q;
	logic   gate_seen_q;
	logic   second_phase_q;
	logic   pend_reload_q;
	logic   out_q;
	state_t state_q;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cclk_q <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			cclk_q <= counter_clock;
			gate_q <= ~gate_input_n;
		end
	end

	// ==========================================================
	// enable logic
	logic fall;
	logic is_gen;
	logic is_pwm;
	logic base_en;
	logic gate_ok;
	logic enabled;

	// edges are seen in the cycle the new level arrives; the counter clock must stay below half mclk
	assign fall    = cclk_q & ~counter_clock;
	assign is_gen  = (mode_select == MODE_DUTY) || (mode_select == MODE_SHOT);
	assign is_pwm  = (mode_select == MODE_PWM);
	assign base_en = soft_run & prescaler_enable & (is_gen | is_pwm);
	// measurement needs the gate; generators only when gate_enable set
	assign gate_ok = is_pwm ? (gate_enable & gate_q & ~gate_seen_q)
	                        : (~gate_enable | gate_q);
	// a finished single shot stays parked until soft_run drops
	assign enabled = base_en & gate_ok & (state_q != ST_DONE);

	// remembers that the measured pulse already ended
	always_ff @(posedge mclk) begin
		if (!nrst || !soft_run) begin
			gate_seen_q <= 1'b0;
		end else if (is_pwm && state_q != ST_IDLE && !gate_q && gate_enable) begin
			gate_seen_q <= 1'b1;
		end
	end

	// ==========================================================
	// sequencer and counter
	logic [CNT_W-1:0] cnt_q;
	logic [PRE_W-1:0] pre_q;
	logic             tick;
	logic             at_zero;
	logic             timeout_evt;
	logic             seq_count;
	logic             load_edge;
	logic             reload_edge;
	logic             dec_edge;
	logic             shot_end;
	logic             new_phase;

	assign tick        = fall & enabled;
	assign at_zero     = (cnt_q == CNT_RST);
	assign seq_count   = (state_q == ST_COUNT);
	assign load_edge   = tick & ((state_q == ST_IDLE) | (state_q == ST_LOAD));
	assign reload_edge = tick & seq_count & pend_reload_q;
	// the fall that finds zero is the time-out; the reload waits one more fall
	assign timeout_evt = tick & seq_count & ~pend_reload_q & at_zero;
	assign dec_edge    = tick & seq_count & ~pend_reload_q & ~at_zero;
	assign shot_end    = timeout_evt & (mode_select == MODE_SHOT) & second_phase_q;
	assign new_phase   = timeout_evt & ~shot_end;

	// ==========================================================
	// sequencer state
	always_ff @(posedge mclk) begin
		if (!nrst || !soft_run) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (load_edge) begin
						state_q <= ST_COUNT;
					end else if (enabled) begin
						state_q <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (load_edge) begin
						state_q <= ST_COUNT;
					end
				end
				ST_COUNT: begin
					if (shot_end) begin
						state_q <= ST_DONE;
					end
				end
				// single shot parks here until soft_run is cleared
				ST_DONE: state_q <= ST_DONE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// counter
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cnt_q <= CNT_RST;
		end else if (load_edge) begin
			cnt_q <= is_pwm ? CNT_ALL_ONE : first_preload;
		end else if (reload_edge && is_pwm) begin
			cnt_q <= CNT_ALL_ONE;
		end else if (reload_edge) begin
			// preload sampled only at this edge; a same-edge write loses
			cnt_q <= second_phase_q ? second_preload
			                        : first_preload;
		end else if (dec_edge) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end

	// ==========================================================
	// reload bookkeeping
	always_ff @(posedge mclk) begin
		if (!nrst || !soft_run) begin
			pend_reload_q <= 1'b0;
		end else if (reload_edge) begin
			pend_reload_q <= 1'b0;
		end else if (new_phase) begin
			pend_reload_q <= 1'b1;
		end
	end

	// measurement always reloads all ones, so it never changes phase
	always_ff @(posedge mclk) begin
		if (!nrst || !soft_run) begin
			second_phase_q <= 1'b0;
		end else if (new_phase) begin
			second_phase_q <= is_pwm ? 1'b0 : ~second_phase_q;
		end
	end

	// ==========================================================
	// prescaler
	// prescaler bits run below the counter, held when stopped
	always_ff @(posedge mclk) begin
		if (!nrst || !soft_run) begin
			pre_q <= PRE_RST;
		end else if (enabled && state_q == ST_COUNT && counter_clock && !cclk_q) begin
			pre_q <= pre_q - 8'h01;
		end
	end

	assign count_register        = cnt_q;
	assign prescaler_output_bits = pre_q;

	// ==========================================================
	// flags; a hardware set wins over a same-cycle clear
	logic cmp_hit;
	logic gate_fall;
	logic gate_prev_q;

	assign cmp_hit = dec_edge && ((cnt_q - 16'h0001) == compare_value);

	// ==========================================================
	// gate edge
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			gate_prev_q <= 1'b0;
		end else begin
			gate_prev_q <= gate_q;
		end
	end

	// measurement reports only the end of its single pulse
	assign gate_fall = gate_prev_q & ~gate_q & gate_enable & base_en
	                   & (state_q == ST_COUNT || state_q == ST_LOAD)
	                   & ~(is_pwm & gate_seen_q);

	// ==========================================================
	// running flag
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			running_flag <= 1'b0;
		end else begin
			running_flag <= enabled;
		end
	end

	// ==========================================================
	// compare flag
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			compare_flag <= 1'b0;
		end else if (cmp_hit) begin
			compare_flag <= 1'b1;
		end else if (timeout_evt || state_q == ST_DONE || !soft_run) begin
			compare_flag <= 1'b0;
		end
	end

	// ==========================================================
	// sticky event flags
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			compare_event_flag <= 1'b0;
		end else if (cmp_hit) begin
			compare_event_flag <= 1'b1;
		end else if (clear_compare_event) begin
			compare_event_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			timeout_flag <= 1'b0;
		end else if (timeout_evt) begin
			timeout_flag <= 1'b1;
		end else if (clear_timeout) begin
			timeout_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			gate_event_flag <= 1'b0;
		end else if (gate_fall) begin
			gate_event_flag <= 1'b1;
		end else if (clear_gate_event) begin
			gate_event_flag <= 1'b0;
		end
	end

	assign gate_level_flag = gate_q;

	// ==========================================================
	// timer output
	// every run starts with the toggle output low
	always_ff @(posedge mclk) begin
		if (!nrst || !soft_run) begin
			out_q <= 1'b0;
		end else if (timeout_evt && output_control == OC_TOGGLE) begin
			out_q <= ~out_q;
		end
	end

	// fixed levels act at once, so the pin also works as a plain port
	always_comb begin
		case (output_control)
			OC_TOGGLE: timer_output = out_q;
			OC_ONE:    timer_output = 1'b1;
			OC_ZERO:   timer_output = 1'b0;
			default:   timer_output = 1'b0;
		endcase
	end

	assign timer_output_oe   = (output_control != OC_HIZ);
	assign output_level_flag = timer_output;

	// ==========================================================
	// interrupt request
	logic [2:0] flag_vec;
	logic [2:0] irq_src;

	assign flag_vec[IE_TIMEOUT] = timeout_flag;
	assign flag_vec[IE_GATE]    = gate_event_flag;
	assign flag_vec[IE_COMPARE] = compare_event_flag;

	generate
		for (genvar i = 0; i < 3; i++) begin : g_irq
			assign irq_src[i] = interrupt_enable_bits[i] & flag_vec[i];
		end
	endgenerate

	assign interrupt_request_line = |irq_src;

endmodule

/* File: verif/timer_pulse_sva.sv */
// assertion checker for the pulse-mode timer
`timescale 1ns/1ns
module timer_pulse_sva
	import timer_pulse_pkg::*;
(
	input wire logic        mclk, nrst, gate_input_n, soft_run,          // clock, reset, pins
	input wire logic        gate_enable, clear_gate_event,               // control
	input wire logic [2:0]  mode_select, interrupt_enable_bits,          // mode, irq enables
	input wire logic [1:0]  output_control,                              // output behaviour
	input wire logic [15:0] count_register,                              // current count
	input wire logic        running_flag, compare_flag, compare_event_flag, // flags
	input wire logic        timeout_flag, gate_event_flag, gate_level_flag, // flags
	input wire logic        output_level_flag, timer_output, timer_output_oe, // output pin
	input wire logic        interrupt_request_line                        // irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// ==========================================
	// assertions
	a_gate_level_track: assert property (
		$stable(gate_input_n)[*2] |-> gate_level_flag == !gate_input_n)
		else $error("gate level flag wrong");
	a_out_level_mirror: assert property (
		output_level_flag == timer_output) else $error("output level flag wrong");
	a_out_drive_enable: assert property (
		timer_output_oe == (output_control != OC_HIZ)) else $error("output enable wrong");
	a_ungated_no_event: assert property (
		!gate_enable && !gate_event_flag |=> !gate_event_flag)
		else $error("gate event set while gate ignored");
	a_zero_clears_cmp: assert property (
		$rose(timeout_flag) |-> !compare_flag) else $error("compare flag kept at zero");
	a_cmp_sets_event: assert property (
		$rose(compare_flag) |-> compare_event_flag) else $error("compare event missing");
	a_gate_event_sticky: assert property (
		soft_run && gate_event_flag && !clear_gate_event |=> gate_event_flag)
		else $error("gate event lost without clear");
	a_irq_from_flags: assert property (
		interrupt_request_line == |(interrupt_enable_bits &
		{compare_event_flag, gate_event_flag, timeout_flag})) else $error("irq wrong");
	a_other_mode_idle: assert property (
		(mode_select == 3'h7)[*2] |-> !running_flag) else $error("unsupported mode ran");
	a_measure_hold: assert property (
		mode_select == 3'h4 && soft_run && gate_event_flag && !running_flag
		|=> $stable(count_register)) else $error("count moved after measurement");
	c_duty: cover property (mode_select == 3'h2 && $rose(timeout_flag));
	c_shot: cover property (mode_select == 3'h3 && $fell(running_flag));
	c_pwm: cover property (mode_select == 3'h4 && $rose(gate_event_flag));
endmodule
bind timer_pulse_modes timer_pulse_sva chk_u (.*);

/* File: verif/far_side_model.sv */
// far-side model: counter clock source and gate pin
`timescale 1ns/1ns
module far_side_model (
	input  wire logic mclk,          // system clock
	input  wire logic gate_on,       // bench asks for gate asserted
	output logic      counter_clock = 1'h1, // counter clock level
	output logic      gate_input_n = 1'h1   // gate pin, active low
);
	int ph = 0;
	// prescaled source runs free, so no framing
	always @(posedge mclk) begin
		ph <= (ph == 2) ? 0 : ph + 1;
		if (ph == 2)
			counter_clock <= ~counter_clock;
		gate_input_n <= ~gate_on;
	end
endmodule

/* File: verif/timer_pulse_modes_test.sv */
// self-checking bench for the pulse-mode timer
`timescale 1ns/1ns
module timer_pulse_modes_test;
	import timer_pulse_pkg::*;
	logic        mclk = 1'h0, nrst = 1'h0, gate_on = 1'h0, cc_q = 1'h1;
	logic        soft_run = 1'h0, prescaler_enable = 1'h0, gate_enable = 1'h0;
	logic        clear_timeout = 1'h0, clear_gate_event = 1'h0, clear_compare_event = 1'h0;
	logic [2:0]  mode_select = 3'h0, interrupt_enable_bits = 3'h0;
	logic [1:0]  output_control = OC_TOGGLE;
	logic [15:0] first_preload = '0, second_preload = '0, compare_value = 16'h1;
	logic [15:0] count_register, c, n1, n2;
	logic [7:0]  prescaler_output_bits;
	logic        counter_clock, gate_input_n, running_flag, compare_flag, compare_event_flag;
	logic        timeout_flag, gate_event_flag, gate_level_flag, output_level_flag;
	logic        timer_output, timer_output_oe, interrupt_request_line;
	int          err_total = 0, n_checks = 0, falls = 0;
	timer_pulse_modes dut_u (.*);
	far_side_model side_u (.*);
	initial forever #2 mclk = ~mclk;
	always @(posedge mclk) begin
		cc_q <= counter_clock;
		if (cc_q && !counter_clock)
			falls <= falls + 1;
	end
	initial begin
		#40000;
		err_total++;
		end_of_test();
	end
	function automatic logic [15:0] width_of(logic [15:0] v);
		return ~v + 16'h1;
	endfunction
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic fw(int n);
		int t;
		t = falls + n;
		while (falls < t)
			@(posedge mclk);
		#1;
	endtask
	// ==========================================
	// flags cleared first, then wait for the next time-out
	task automatic wait_to();
		@(posedge mclk);
		clear_timeout <= 1'h1;
		clear_compare_event <= 1'h1;
		@(posedge mclk);
		clear_timeout <= 1'h0;
		clear_compare_event <= 1'h0;
		@(posedge mclk);
		for (int i = 0; i < 200 && timeout_flag !== 1'h1; i++) begin
			@(posedge mclk);
			#1;
		end
		chk("timeout seen", 16'h1, 16'(timeout_flag));
	endtask
	// started just after a fall so the first load edge is unambiguous
	task automatic start(logic [2:0] m, logic g, logic [15:0] p1, logic [15:0] p2);
		fw(1);
		@(posedge mclk);
		soft_run <= 1'h0;
		mode_select <= m;
		gate_enable <= g;
		first_preload <= p1;
		second_preload <= p2;
		compare_value <= 16'(1 + $urandom % 2);
		interrupt_enable_bits <= 3'($urandom);
		clear_gate_event <= 1'h1;
		@(posedge mclk);
		clear_gate_event <= 1'h0;
		soft_run <= 1'h1;
		prescaler_enable <= 1'h1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================
	// tests
	initial begin
		void'($urandom(22));
		repeat (6) @(posedge mclk);
		nrst <= 1'h1;
		@(posedge mclk);
		#1;
		chk("count reset", CNT_RST, count_register);
		chk("prescaler reset", 16'(PRE_RST), 16'(prescaler_output_bits));
		repeat (3) begin
			n1 = 16'(3 + $urandom % 6);
			n2 = 16'(3 + $urandom % 6);
			start(MODE_DUTY, 1'h0, n1, n2);
			fw(1);
			chk("first load", n1, count_register);
			chk("running", 16'h1, 16'(running_flag));
			for (int k = 0; k < 2; k++) begin
				gate_on <= 1'($urandom);
				wait_to();
				chk("toggle", 16'(k == 0), 16'(timer_output));
				chk("cmp event", 16'h1, 16'(compare_event_flag));
				fw(1);
				chk("reload", k ? n1 : n2, count_register);
			end
			chk("gate ignored", 16'h0, 16'(gate_event_flag));
		end
		$display("duty test done");
		gate_on <= 1'h1;
		start(MODE_DUTY, 1'h1, 16'h40, 16'h3);
		fw(4);
		gate_on <= 1'h0;
		fw(2);
		c = count_register;
		fw(3);
		chk("held", c, count_register);
		chk("stopped", 16'h0, 16'(running_flag));
		gate_on <= 1'h1;
		fw(3);
		chk("resumed", 16'h1, 16'((c - count_register) inside {[1:3]} && running_flag));
		chk("event kept", 16'h1, 16'(gate_event_flag));
		$display("gate test done");
		n1 = 16'(3 + $urandom % 4);
		n2 = 16'(3 + $urandom % 4);
		start(MODE_SHOT, 1'h0, n1, n2);
		fw(1);
		chk("shot low", 16'h0, 16'(timer_output));
		wait_to();
		chk("shot high", 16'h1, 16'(timer_output));
		fw(1);
		chk("width load", n2, count_register);
		wait_to();
		chk("shot end low", 16'h0, 16'(timer_output));
		fw(2);
		c = count_register;
		fw(3);
		chk("shot held", c, count_register);
		chk("shot idle", 16'h0, 16'({running_flag, compare_flag}));
		$display("shot test done");
		gate_on <= 1'h0;
		start(MODE_PWM, 1'h1, 16'h5, 16'h7);
		fw(2);
		gate_on <= 1'h1;
		fw(9);
		gate_on <= 1'h0;
		fw(3);
		c = count_register;
		chk("all ones", 16'hFF, 16'(c[15:8]));
		chk("width", 16'h1, 16'(width_of(c) inside {[8:10]}));
		chk("measure stop", 16'h1, 16'({running_flag, gate_event_flag}));
		gate_on <= 1'h1;
		fw(3);
		chk("no restart", c, count_register);
		$display("measure test done");
		start(3'h7, 1'h0, 16'h3, 16'h3);
		fw(3);
		chk("other idle", 16'h0, 16'(running_flag));
		@(posedge mclk);
		soft_run <= 1'h0;
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			output_control <= 2'(k);
			@(posedge mclk);
			#1;
			chk("pin drive", 16'(k != 0), 16'(timer_output_oe));
			if (k > 1)
				chk("pin level", 16'(k - 2), 16'(timer_output));
		end
		$display("output test done");
		end_of_test();
	end
endmodule
